// [src/pfm_pkg.sv]
package pfm_pkg;

  // Bus and pin geometry
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned FIRST_PIN = 2;
  localparam int unsigned ANALOG_LAST_PIN = 3;
  localparam int unsigned DIAG_LAST_PIN = 7;

  // Register offsets, kept as printed
  localparam logic [31:0] PIN2_MODE_OFFSET = 32'h5000300A;
  localparam logic [31:0] PIN3_MODE_OFFSET = 32'h5000300C;
  localparam logic [31:0] PIN4_MODE_OFFSET = 32'h5000300E;
  localparam logic [31:0] PIN5_MODE_OFFSET = 32'h50003010;
  localparam logic [31:0] PIN_STATUS_OFFSET = 32'h50003030;
  localparam logic [31:0] PIN_REFUSED_OFFSET = 32'h50003032;

  // Field positions
  localparam int unsigned FUNC_LSB = 0;
  localparam int unsigned FUNC_MSB = 4;
  localparam int unsigned PULL_LSB = 8;
  localparam int unsigned PULL_MSB = 9;
  localparam int unsigned STATUS_LEVEL_LSB = 0;
  localparam int unsigned STATUS_CONFLICT_LSB = 4;

  // Pull configuration codes and reset values
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] PULL_OUTPUT = 2'h3;
  localparam logic [1:0] PULL_RESET = 2'h2;
  localparam logic [4:0] FUNC_RESET = 5'h00;

  // Peripheral input functions and the level they see when unclaimed
  localparam int unsigned IN_FUNC_COUNT = 9;
  localparam logic [8:0] IN_IDLE_LEVEL = 9'h1FF;

  typedef enum logic [4:0] {
    FUNC_GPIO = 5'h00, FUNC_SA_RX = 5'h01, FUNC_SA_TX = 5'h02, FUNC_SB_RX = 5'h03,
    FUNC_SB_TX = 5'h04, FUNC_SP_DI = 5'h05, FUNC_SP_DO = 5'h06, FUNC_SP_CLK = 5'h07,
    FUNC_SP_EN = 5'h08, FUNC_TW_CLK = 5'h09, FUNC_TW_DATA = 5'h0A, FUNC_SA_IR_RX = 5'h0B,
    FUNC_SA_IR_TX = 5'h0C, FUNC_SB_IR_RX = 5'h0D, FUNC_SB_IR_TX = 5'h0E, FUNC_ANALOG = 5'h0F,
    FUNC_PULSE0 = 5'h10, FUNC_PULSE1 = 5'h11, FUNC_DIAG = 5'h12, FUNC_SA_CTS = 5'h13,
    FUNC_SA_RTS = 5'h14, FUNC_SB_CTS = 5'h15, FUNC_SB_RTS = 5'h16, FUNC_PULSE2 = 5'h17,
    FUNC_PULSE3 = 5'h18, FUNC_PULSE4 = 5'h19
  } pfm_func_t;

  typedef struct packed {
    logic [1:0] pullConfig;
    pfm_func_t functionSelect;
  } pfm_mode_t;

  // Signals the peripherals drive towards the pins
  typedef struct packed {
    logic serialATransmit;
    logic serialBTransmit;
    logic serialAInfraredTransmit;
    logic serialBInfraredTransmit;
    logic serialARequestToSendN;
    logic serialBRequestToSendN;
    logic serialPeriphDataOut;
    logic serialPeriphClock;
    logic serialPeriphEnable;
    logic twoWireClockLow;
    logic twoWireDataLow;
    logic [4:0] pulseOut;
    logic radioDiagOut;
  } pfm_periph_out_t;

  // Signals the pins feed to the peripherals
  typedef struct packed {
    logic serialAReceive;
    logic serialBReceive;
    logic serialPeriphDataIn;
    logic twoWireClockIn;
    logic twoWireDataIn;
    logic serialAInfraredReceive;
    logic serialBInfraredReceive;
    logic serialAClearToSendN;
    logic serialBClearToSendN;
  } pfm_periph_in_t;

  // Returns {pullUp, pullDown} for a pull configuration code
  function automatic logic [1:0] pfm_pull_decode(input logic [1:0] code);
    pfm_pull_decode = {code == PULL_UP, code == PULL_DOWN};
  endfunction : pfm_pull_decode

endpackage : pfm_pkg

// [src/pfm_pin_cell.sv]
module pfm_pin_cell #(
  parameter int unsigned PIN_INDEX = 2
) (
  input pfm_pkg::pfm_mode_t mode,
  input pfm_pkg::pfm_periph_out_t periphOut,
  input logic gpioOut,
  output logic next_padOut,
  output logic next_padOe,
  output logic next_pullUp,
  output logic next_pullDown,
  output logic next_analog,
  output logic next_refused,
  output pfm_pkg::pfm_periph_in_t claim
);

  logic [1:0] pulls;

  // Port function is the fallback; each selected function overrides it
  always_comb begin
    pulls = pfm_pkg::pfm_pull_decode(mode.pullConfig);
    claim = '0;
    next_padOut = gpioOut;
    next_padOe = (mode.pullConfig == pfm_pkg::PULL_OUTPUT);
    next_analog = 1'b0;
    next_refused = 1'b0;
    unique case (mode.functionSelect)
      pfm_pkg::FUNC_GPIO: begin
        next_refused = 1'b0;
      end
      pfm_pkg::FUNC_SA_RX: begin next_padOe = 1'b0; claim.serialAReceive = 1'b1; end
      pfm_pkg::FUNC_SA_TX: begin next_padOe = 1'b1; next_padOut = periphOut.serialATransmit; end
      pfm_pkg::FUNC_SB_RX: begin next_padOe = 1'b0; claim.serialBReceive = 1'b1; end
      pfm_pkg::FUNC_SB_TX: begin next_padOe = 1'b1; next_padOut = periphOut.serialBTransmit; end
      pfm_pkg::FUNC_SP_DI: begin next_padOe = 1'b0; claim.serialPeriphDataIn = 1'b1; end
      pfm_pkg::FUNC_SP_DO: begin next_padOe = 1'b1; next_padOut = periphOut.serialPeriphDataOut; end
      pfm_pkg::FUNC_SP_CLK: begin next_padOe = 1'b1; next_padOut = periphOut.serialPeriphClock; end
      pfm_pkg::FUNC_SP_EN: begin next_padOe = 1'b1; next_padOut = periphOut.serialPeriphEnable; end
      // Two-wire lines are open drain: only ever pulled low
      pfm_pkg::FUNC_TW_CLK: begin
        next_padOe = periphOut.twoWireClockLow;
        next_padOut = 1'b0;
        claim.twoWireClockIn = 1'b1;
      end
      pfm_pkg::FUNC_TW_DATA: begin
        next_padOe = periphOut.twoWireDataLow;
        next_padOut = 1'b0;
        claim.twoWireDataIn = 1'b1;
      end
      pfm_pkg::FUNC_SA_IR_RX: begin next_padOe = 1'b0; claim.serialAInfraredReceive = 1'b1; end
      pfm_pkg::FUNC_SA_IR_TX: begin
        next_padOe = 1'b1;
        next_padOut = periphOut.serialAInfraredTransmit;
      end
      pfm_pkg::FUNC_SB_IR_RX: begin next_padOe = 1'b0; claim.serialBInfraredReceive = 1'b1; end
      pfm_pkg::FUNC_SB_IR_TX: begin
        next_padOe = 1'b1;
        next_padOut = periphOut.serialBInfraredTransmit;
      end
      // Pins above the analog range stay on the port function
      pfm_pkg::FUNC_ANALOG: begin
        if (PIN_INDEX <= pfm_pkg::ANALOG_LAST_PIN) begin
          next_padOe = 1'b0;
          next_analog = 1'b1;
        end else begin
          next_refused = 1'b1;
        end
      end
      pfm_pkg::FUNC_PULSE0: begin next_padOe = 1'b1; next_padOut = periphOut.pulseOut[0]; end
      pfm_pkg::FUNC_PULSE1: begin next_padOe = 1'b1; next_padOut = periphOut.pulseOut[1]; end
      pfm_pkg::FUNC_DIAG: begin
        if (PIN_INDEX <= pfm_pkg::DIAG_LAST_PIN) begin
          next_padOe = 1'b1;
          next_padOut = periphOut.radioDiagOut;
        end else begin
          next_refused = 1'b1;
        end
      end
      pfm_pkg::FUNC_SA_CTS: begin next_padOe = 1'b0; claim.serialAClearToSendN = 1'b1; end
      pfm_pkg::FUNC_SA_RTS: begin next_padOe = 1'b1; next_padOut = periphOut.serialARequestToSendN; end
      pfm_pkg::FUNC_SB_CTS: begin next_padOe = 1'b0; claim.serialBClearToSendN = 1'b1; end
      pfm_pkg::FUNC_SB_RTS: begin next_padOe = 1'b1; next_padOut = periphOut.serialBRequestToSendN; end
      pfm_pkg::FUNC_PULSE2: begin next_padOe = 1'b1; next_padOut = periphOut.pulseOut[2]; end
      pfm_pkg::FUNC_PULSE3: begin next_padOe = 1'b1; next_padOut = periphOut.pulseOut[3]; end
      pfm_pkg::FUNC_PULSE4: begin next_padOe = 1'b1; next_padOut = periphOut.pulseOut[4]; end
      // Codes 26 to 31 have no function behind them
      default: begin
        next_refused = 1'b1;
      end
    endcase
    // Resistors only on a pin that is not driven and not analog
    next_pullUp = pulls[1] & ~next_padOe & ~next_analog;
    next_pullDown = pulls[0] & ~next_padOe & ~next_analog;
  end

endmodule : pfm_pin_cell

// [src/pfm_port0_pin_function_mux.sv]
// Behaviour
// - Pull codes 00, 01, 10 and 11 give input bare, input pulled up, input pulled down, output.
// - Every pin mode register resets with its pull configuration at 0x2, a pulled-down input.
// - A pin routed to the converter input ignores the pull configuration entirely.
// - Function 0 is the plain port pin, with direction and pull from the pull configuration.
// - Functions 1 to 4 are serial A receive, serial A transmit, serial B receive, serial B transmit.
// - Function 15 routes to the converter input, honoured only on port pins 0 to 3.
// - Function 18 drives the radio diagnostic signal, available on port pins 0 to 7.
// - An input function chosen on several pins is fed from the lowest pin, port 0 before port 1.
module pfm_port0_pin_function_mux (
  input logic ref_clk,
  input logic rst,
  input logic [31:0] regAddr,
  input logic [15:0] regWrData,
  input logic regWrStb,
  input logic regRdStb,
  output logic [15:0] regRdData,
  input logic [3:0] padIn,
  output logic [3:0] padOut,
  output logic [3:0] padOe,
  output logic [3:0] pullUpEn,
  output logic [3:0] pullDownEn,
  output logic [3:0] analogEn,
  input logic [3:0] gpioOut,
  output logic [3:0] gpioIn,
  input pfm_pkg::pfm_periph_out_t periphOut,
  input pfm_pkg::pfm_periph_in_t upstreamValid,
  input pfm_pkg::pfm_periph_in_t upstreamLevel,
  output pfm_pkg::pfm_periph_in_t periphIn,
  output pfm_pkg::pfm_periph_in_t periphInValid
);

  localparam int unsigned PC = pfm_pkg::PIN_COUNT;
  localparam int unsigned NF = pfm_pkg::IN_FUNC_COUNT;

  // Mode registers, index 0 is pin 2
  pfm_pkg::pfm_mode_t modeReg [PC];

  // Pin synchroniser stages
  logic [3:0] padInMeta;
  logic [3:0] padInSync;

  // Per-pin decode results
  logic [3:0] nextPadOut;
  logic [3:0] nextPadOe;
  logic [3:0] nextPullUp;
  logic [3:0] nextPullDown;
  logic [3:0] nextAnalog;
  logic [3:0] nextRefused;
  pfm_pkg::pfm_periph_in_t claimArr [PC];

  // Input routing results
  pfm_pkg::pfm_periph_in_t next_periphIn;
  pfm_pkg::pfm_periph_in_t next_periphInValid;
  logic [NF-1:0] next_conflict;

  // Status seen by software
  logic [NF-1:0] conflict;
  logic [3:0] refused;

  // Address decode shared by the write and read paths
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    unique case (addr)
      pfm_pkg::PIN2_MODE_OFFSET: slot_of = 3'h4;
      pfm_pkg::PIN3_MODE_OFFSET: slot_of = 3'h5;
      pfm_pkg::PIN4_MODE_OFFSET: slot_of = 3'h6;
      pfm_pkg::PIN5_MODE_OFFSET: slot_of = 3'h7;
      default: slot_of = 3'h0;
    endcase
  endfunction : slot_of

  // Decoded slot of the current bus address, shared by both paths
  logic [2:0] slot;
  assign slot = slot_of(regAddr);

  // Packs a mode register into its 16-bit register image
  function automatic logic [15:0] image_of(input pfm_pkg::pfm_mode_t m);
    logic [15:0] img;
    img = 16'h0000;
    img[pfm_pkg::PULL_MSB:pfm_pkg::PULL_LSB] = m.pullConfig;
    img[pfm_pkg::FUNC_MSB:pfm_pkg::FUNC_LSB] = m.functionSelect;
    image_of = img;
  endfunction : image_of

  // Mode register writes; reserved bits are simply not stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < PC; i++) begin
        modeReg[i].pullConfig <= pfm_pkg::PULL_RESET;
        modeReg[i].functionSelect <= pfm_pkg::FUNC_GPIO;
      end
    end else if (regWrStb && slot[2]) begin
      modeReg[slot[1:0]].pullConfig <=
        regWrData[pfm_pkg::PULL_MSB:pfm_pkg::PULL_LSB];
      modeReg[slot[1:0]].functionSelect <=
        pfm_pkg::pfm_func_t'(regWrData[pfm_pkg::FUNC_MSB:pfm_pkg::FUNC_LSB]);
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else if (!regRdStb) begin
      regRdData <= 16'h0000;
    end else if (slot[2]) begin
      regRdData <= image_of(modeReg[slot[1:0]]);
    end else if (regAddr == pfm_pkg::PIN_STATUS_OFFSET) begin
      regRdData <= 16'({conflict, padInSync}); // pin levels low, conflicts above
    end else if (regAddr == pfm_pkg::PIN_REFUSED_OFFSET) begin
      regRdData <= {12'h000, refused};
    end else begin
      regRdData <= 16'h0000; // Unmapped address reads as zero
    end
  end

  // Two-stage synchroniser; pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      padInMeta <= 4'h0;
      padInSync <= 4'h0;
    end else begin
      padInMeta <= padIn;
      padInSync <= padInMeta;
    end
  end

  // One decode cell per pin, each knowing its own pin number
  for (genvar p = 0; p < PC; p++) begin : g_pin
    pfm_pin_cell #(
      .PIN_INDEX(pfm_pkg::FIRST_PIN + p)
    ) u_cell (
      .mode(modeReg[p]),
      .periphOut(periphOut),
      .gpioOut(gpioOut[p]),
      .next_padOut(nextPadOut[p]),
      .next_padOe(nextPadOe[p]),
      .next_pullUp(nextPullUp[p]),
      .next_pullDown(nextPullDown[p]),
      .next_analog(nextAnalog[p]),
      .next_refused(nextRefused[p]),
      .claim(claimArr[p])
    );
  end

  // Input routing: lower pins on port 0 arrive as the upstream claim and
  // win outright; among our pins the scan runs downwards so the lowest
  // claimant is assigned last and therefore wins.
  always_comb begin
    next_periphIn = pfm_pkg::pfm_periph_in_t'(pfm_pkg::IN_IDLE_LEVEL);
    next_periphInValid = upstreamValid;
    for (int f = 0; f < NF; f++) begin
      if (upstreamValid[f]) begin
        next_periphIn[f] = upstreamLevel[f];
      end else begin
        for (int p = PC - 1; p >= 0; p--) begin
          if (claimArr[p][f]) begin
            next_periphIn[f] = padInSync[p];
            next_periphInValid[f] = 1'b1;
          end
        end
      end
    end
  end

  // Flags an input function claimed on more than one of our pins or
  // already claimed upstream; the lower pin still wins, this only reports.
  always_comb begin
    logic seen;
    seen = 1'b0;
    next_conflict = '0;
    for (int f = 0; f < NF; f++) begin
      seen = upstreamValid[f];
      for (int p = 0; p < PC; p++) begin
        if (claimArr[p][f]) begin
          if (seen) begin
            next_conflict[f] = 1'b1;
          end
          seen = 1'b1;
        end
      end
    end
  end

  // Pin drive and resistor controls, registered for clean pad timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      padOut <= 4'h0;
      padOe <= 4'h0;
      pullUpEn <= 4'h0;
      pullDownEn <= 4'hF; // Pulled-down inputs from reset
      analogEn <= 4'h0;
    end else begin
      padOut <= nextPadOut;
      padOe <= nextPadOe;
      pullUpEn <= nextPullUp;
      pullDownEn <= nextPullDown;
      analogEn <= nextAnalog;
    end
  end

  // Peripheral input levels, one cycle behind the synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      periphIn <= pfm_pkg::pfm_periph_in_t'(pfm_pkg::IN_IDLE_LEVEL);
      periphInValid <= '0;
    end else begin
      periphIn <= next_periphIn;
      periphInValid <= next_periphInValid;
    end
  end

  // Port-function input levels; all pins are visible whatever their function
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gpioIn <= 4'h0;
    end else begin
      gpioIn <= padInSync;
    end
  end

  // Status for software: live, not sticky, so no clear is needed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conflict <= '0;
      refused <= 4'h0;
    end else begin
      conflict <= next_conflict;
      refused <= nextRefused;
    end
  end

endmodule : pfm_port0_pin_function_mux

// [verif/pfm_mux_properties.sv]
module pfm_mux_checker (
  input logic ref_clk,
  input logic rst,
  input logic [31:0] regAddr,
  input logic regRdStb,
  input logic [15:0] regRdData,
  input logic [3:0] padIn,
  input logic [3:0] padOe,
  input logic [3:0] pullUpEn,
  input logic [3:0] pullDownEn,
  input logic [3:0] analogEn,
  input logic [3:0] gpioIn,
  input pfm_pkg::pfm_periph_in_t upstreamValid,
  input pfm_pkg::pfm_periph_in_t upstreamLevel,
  input pfm_pkg::pfm_periph_in_t periphIn,
  input pfm_pkg::pfm_periph_in_t periphInValid
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Register bus
  a_read_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
    else $error("read data outside read slot");
  a_reserved_read_zero: assert property ($past(regRdStb)
    && $past(regAddr) >= pfm_pkg::PIN2_MODE_OFFSET && $past(regAddr) <= pfm_pkg::PIN5_MODE_OFFSET
    |-> (regRdData & 16'hFCE0) == 16'h0000)
    else $error("reserved mode bits read back set");
  // Pad controls
  a_reset_pull_down: assert property ($past(rst) |->
    pullDownEn == 4'hF && pullUpEn == 4'h0 && padOe == 4'h0 && analogEn == 4'h0)
    else $error("pads not pulled-down inputs after reset");
  a_pull_exclusive: assert property ((pullUpEn & pullDownEn) == 4'h0)
    else $error("pull-up and pull-down together");
  a_analog_no_pull: assert property ((analogEn & (pullUpEn | pullDownEn | padOe)) == 4'h0)
    else $error("converter pin has pull or drive");
  a_analog_low_pins: assert property (analogEn[3:2] == 2'h0)
    else $error("converter routing on pin 4 or 5");
  // Input path; the window of four keeps pre-reset samples out
  a_pad_sync_delay: assert property ((!rst) [*4] |-> gpioIn == $past(padIn, 3))
    else $error("port input not three edges behind pad");
  a_unclaimed_idle: assert property ((periphIn | periphInValid) == 9'h1FF)
    else $error("unclaimed peripheral input not idle high");
  a_upstream_wins: assert property (($stable(upstreamValid) && $stable(upstreamLevel)) [*4]
    |-> (upstreamValid & ~periphInValid) == 9'h000 && ((periphIn ^ upstreamLevel) & upstreamValid) == 9'h000)
    else $error("upstream claim not honoured");

  cover property (analogEn != 4'h0);
  cover property (padOe != 4'h0);
  cover property ((periphInValid & ~upstreamValid) != 9'h000);
endmodule : pfm_mux_checker

bind pfm_port0_pin_function_mux pfm_mux_checker u_pfm_mux_checker (.ref_clk, .rst, .regAddr,
  .regRdStb, .regRdData, .padIn, .padOe, .pullUpEn, .pullDownEn, .analogEn, .gpioIn,
  .upstreamValid, .upstreamLevel, .periphIn, .periphInValid);

// [verif/pfm_pads.sv]
module pfm_pads (
  input logic ref_clk,
  input logic [3:0] padOut,
  input logic [3:0] padOe,
  input logic [3:0] pullUpEn,
  input logic [3:0] pullDownEn,
  input logic [3:0] extLvl,
  input logic [3:0] extEn,
  output logic [3:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drift = 4'h5;
  // A released unpulled line wanders, so a stale level never passes
  always_ff @(posedge ref_clk) drift <= ~drift;
  // Wire level: the block's drive, else the outside driver, else the pulls
  assign padIn = (padOe & padOut) | (~padOe & ((extEn & extLvl)
    | (~extEn & (pullUpEn | (~pullDownEn & drift)))));
endmodule : pfm_pads

// [verif/pfm_port0_pin_function_mux_tb.sv]
module pfm_port0_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] regAddr = 32'h0;
  logic [15:0] regWrData = 16'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [3:0] gpioOut = 4'h0;
  logic [3:0] extLvl = 4'h0;
  logic [3:0] extEn = 4'h0;
  pfm_pkg::pfm_periph_out_t periphOut = '0;
  pfm_pkg::pfm_periph_in_t upV = '0;
  pfm_pkg::pfm_periph_in_t upL = '0;
  logic [15:0] regRdData;
  logic [3:0] padIn, padOut, padOe, pullUpEn, pullDownEn, analogEn, gpioIn;
  pfm_pkg::pfm_periph_in_t periphIn, periphInValid;
  logic [15:0] rdQ[$];
  logic [37:0] pinQ[$];
  logic [3:0] lvQ[$];
  logic [15:0] mode[4] = '{default: 16'h0200};
  logic [31:0] seed = 32'h00009EC5;
  logic rdPend = 1'b0;
  logic pinReq = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Bit of periphOut and of periphIn that each function code uses
  int outPos[32] = '{2:16, 4:15, 12:14, 14:13, 20:12, 22:11, 6:10, 7:9, 8:8, 9:7, 10:6,
    16:1, 17:2, 23:3, 24:4, 25:5, 18:0, default:-1};
  int inPos[32] = '{1:8, 3:7, 5:6, 9:5, 10:4, 11:3, 13:2, 19:1, 21:0, default:-1};

  always #25 ref_clk = ~ref_clk;

  pfm_port0_pin_function_mux u_pfm_port0_pin_function_mux (.ref_clk, .rst, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .padIn, .padOut, .padOe, .pullUpEn, .pullDownEn, .analogEn,
    .gpioOut, .gpioIn, .periphOut, .upstreamValid(upV), .upstreamLevel(upL), .periphIn,
    .periphInValid);
  pfm_pads u_pfm_pads (.ref_clk, .padOut, .padOe, .pullUpEn, .pullDownEn, .extLvl, .extEn, .padIn);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] base(input int p);
    return pfm_pkg::PIN2_MODE_OFFSET + 32'(2 * p);
  endfunction : base

  // Expected pads and peripheral inputs from the stored modes
  function automatic logic [37:0] exp_pins();
    logic [3:0] oe, ou, up, dn, an, lv;
    logic [8:0] pv, pl;
    logic [16:0] v;
    logic [4:0] f;
    logic [1:0] pc;
    v = periphOut;
    pv = upV;
    pl = upL | ~upV;
    // Walk downwards so the lowest pin claims last and wins
    for (int p = 3; p >= 0; p--) begin
      f = mode[p][4:0];
      pc = mode[p][9:8];
      if (f > 5'h19 || (f == 5'h0F && p > 1)) f = 5'h00;
      an[p] = (f == 5'h0F);
      up[p] = !an[p] && pc == 2'h1;
      dn[p] = !an[p] && pc == 2'h2;
      oe[p] = (f == 5'h00 && pc == 2'h3);
      ou[p] = oe[p] & gpioOut[p];
      if (f == 5'h09 || f == 5'h0A) begin
        oe[p] = v[outPos[f]];
      end else if (outPos[f] >= 0) begin
        oe[p] = 1'b1;
        ou[p] = v[outPos[f]];
      end
      up[p] = up[p] & !oe[p];
      dn[p] = dn[p] & !oe[p];
      lv[p] = oe[p] ? ou[p] : (up[p] | dn[p]) ? up[p] : extLvl[p];
      if (inPos[f] >= 0 && !upV[inPos[f]]) begin
        pv[inPos[f]] = 1'b1;
        pl[inPos[f]] = lv[p];
      end
    end
    return {oe, ou, up, dn, an, pl, pv};
  endfunction : exp_pins

  // Settled wire level per pin: own drive, else pull, else the outside level
  function automatic logic [3:0] exp_level(input logic [37:0] e);
    return (e[37:34] & e[33:30]) | (~e[37:34] & e[29:26])
      | (~e[37:34] & ~e[29:26] & ~e[25:22] & extLvl);
  endfunction : exp_level

  // An input function claimed again after upstream or a lower pin
  function automatic logic [8:0] exp_conflict();
    logic [8:0] seen;
    logic [8:0] cf;
    int k;
    seen = upV;
    cf = 9'h000;
    for (int p = 0; p < 4; p++) begin
      k = inPos[mode[p][4:0]];
      if (k >= 0) begin
        cf[k] = cf[k] | seen[k];
        seen[k] = 1'b1;
      end
    end
    return cf;
  endfunction : exp_conflict

  // Codes past the table, and converter routing above the analog pins
  function automatic logic [3:0] exp_refused();
    logic [3:0] rf;
    logic [4:0] f;
    for (int p = 0; p < 4; p++) begin
      f = mode[p][4:0];
      rf[p] = f > 5'h19 || (f == 5'h0F && p > 1);
    end
    return rf;
  endfunction : exp_refused

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk38(input logic [37:0] got, input logic [37:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk38

  // Strobes are set every call, so back-to-back cycles never assign twice
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d,
      input logic [15:0] e);
    regWrStb <= w;
    regRdStb <= !w;
    regAddr <= a;
    regWrData <= d;
    if (!w) rdQ.push_back(e);
    @(posedge ref_clk);
  endtask : bus

  task automatic idle(input int n);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic check_pins(input logic [37:0] e, input logic [3:0] l);
    pinQ.push_back(e);
    lvQ.push_back(l);
    pinReq <= 1'b1;
    @(posedge ref_clk);
    pinReq <= 1'b0;
  endtask : check_pins

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Watcher: takes the oldest note whenever a result is due
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rdPend) chk16(regRdData, rdQ.pop_front());
    if (pinReq) chk38({padOe, padOut & padOe, pullUpEn, pullDownEn, analogEn, periphIn,
      periphInValid}, pinQ.pop_front());
    if (pinReq) chk16({12'h000, gpioIn}, {12'h000, lvQ.pop_front()});
    rdPend <= regRdStb;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Random modes on all pins, back-to-back bus cycles, then settle and compare
  initial begin
    logic [31:0] r;
    logic [37:0] e;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    check_pins(exp_pins(), 4'h0);
    for (int p = 0; p < 4; p++) bus(1'b0, base(p), 16'h0, 16'h0200);
    for (int it = 0; it < 300; it++) begin
      r = rnd();
      periphOut <= pfm_pkg::pfm_periph_out_t'(r[16:0]);
      gpioOut <= r[20:17];
      extLvl <= r[24:21];
      r = rnd();
      upV <= pfm_pkg::pfm_periph_in_t'(r[8:0] & r[17:9] & r[26:18]);
      upL <= pfm_pkg::pfm_periph_in_t'(r[31:23]);
      for (int p = 0; p < 4; p++) begin
        r = rnd();
        // Pin 4 often copies pin 2 so shared inputs collide
        if (p == 2 && r[31]) r[4:0] = mode[0][4:0];
        mode[p] = r[15:0] & 16'h031F;
        bus(1'b1, base(p), r[15:0], 16'h0);
      end
      bus(1'b1, 32'h50003008, r[31:16], 16'h0);
      for (int p = 0; p < 4; p++) bus(1'b0, base(p), 16'h0, mode[p]);
      bus(1'b0, 32'h50003008, 16'h0, 16'h0);
      bus(1'b0, pfm_pkg::PIN_REFUSED_OFFSET, 16'h0, {12'h000, exp_refused()});
      idle(2);
      e = exp_pins();
      extEn <= ~(e[37:34] | e[29:26] | e[25:22]);
      idle(5);
      check_pins(e, exp_level(e));
      bus(1'b0, pfm_pkg::PIN_STATUS_OFFSET, 16'h0,
        {3'h0, exp_conflict(), exp_level(e)});
    end
    // Let the last notes be compared before the verdict
    idle(3);
    end_of_test();
  end
endmodule : pfm_port0_pin_function_mux_tb
